// [adc_params.svh]
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

`define MCLK_MHZ 40
`define T_CONV_FAST_NS 825
`define T_CONV_NORM_NS 925
`define CYC_CONV_FAST ((`T_CONV_FAST_NS * `MCLK_MHZ + 999) / 1000)
`define CYC_CONV_NORM ((`T_CONV_NORM_NS * `MCLK_MHZ + 999) / 1000)
`define CONV_CNT_W 6
`define WORD_BITS 16
`define FRAME_BITS 32
`define RX_CNT_W 5
`define TX_CNT_W 5
`define CFG_RESET 16'h0002
`define CFG_MODE_BIT 1
`define MODE_FAST 1'h0
`define MODE_NORMAL 1'h1
`define FIFO_DEPTH 8

`endif

// [adc_pkg.sv]
`include "adc_params.svh"

package adc_pkg;

  typedef enum logic {
    CONV_IDLE,
    CONV_RUN
  } conv_state_t;

  typedef struct packed {
    logic [1:0] cnv_sync;
    logic cnv_prev;
    logic [1:0] pd_sync;
    logic [1:0] wr_sync;
    logic wr_prev;
    logic [1:0] rd_sync;
    logic rd_prev;
    conv_state_t st;
    logic [`CONV_CNT_W-1:0] cyc;
    logic mode;
    logic [`WORD_BITS-1:0] cfg_active;
    logic [`WORD_BITS-1:0] cfg_pending;
    logic [`FRAME_BITS-1:0] word;
    logic consumed;
    logic busy;
    logic sample;
  } ctrl_state_t;

  typedef struct packed {
    logic [`WORD_BITS-1:0] shift;
    logic [`RX_CNT_W-1:0] cnt;
  } rx_state_t;

  typedef struct packed {
    logic [`TX_CNT_W-1:0] cnt;
  } tx_state_t;

endpackage : adc_pkg

// [sar_adc_serial_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_params.svh"

// Overview of operation
// - rising convert strobe starts a conversion
// - busy high throughout conversion, low at end
// - 16-bit config word captured on sck rise
// - result leaves serial output in two's complement
// - end of conversion updates result and config
// - result shifted out over 16 sck falls
// - next 16 falls shift out the config word
// - mode bit: 0 fast, 1 normal default
// - data ready 825 ns fast, 925 ns normal
// - busy rises within 520 ns of strobe

module sample_fifo #(
  parameter int WIDTH = `FRAME_BITS,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready = (q.fill != FULL);
  assign out_valid = (q.fill != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = bump(q.wp);
    end
    if (pop) begin
      d.rp = bump(q.rp);
    end
    unique case ({push, pop})
      2'h2: d.fill = q.fill + 1'b1;
      2'h1: d.fill = q.fill - 1'b1;
      default: d.fill = q.fill;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : sample_fifo

module sar_adc_serial_core
  import adc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic convert_strobe,
  input wire logic power_down_input,
  input wire logic [`WORD_BITS-1:0] sar_result,
  output logic busy,
  output logic sample_start,
  output logic conversion_mode_select,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe
);
  localparam ctrl_state_t CTRL_RST = '{
    st: CONV_IDLE,
    cfg_active: `CFG_RESET,
    cfg_pending: `CFG_RESET,
    mode: `MODE_NORMAL,
    consumed: 1'h1,
    default: '0
  };

  ctrl_state_t q;
  ctrl_state_t d;
  rx_state_t rx_q;
  rx_state_t rx_d;
  tx_state_t tx_q;
  tx_state_t tx_d;

  logic link_rst;
  logic cnv_rise;
  logic pd;
  logic conv_done;
  logic wr_done;
  logic rd_end;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [`FRAME_BITS-1:0] f_out_data;
  logic [`FRAME_BITS-1:0] f_in_data;

  function automatic logic [`CONV_CNT_W-1:0] conv_last(input logic mode);
    if (mode == `MODE_NORMAL) begin
      conv_last = `CONV_CNT_W'(`CYC_CONV_NORM - 1);
    end else begin
      conv_last = `CONV_CNT_W'(`CYC_CONV_FAST - 1);
    end
  endfunction : conv_last

  // events seen only after their two-stage synchronisers
  assign cnv_rise = q.cnv_sync[1] & ~q.cnv_prev;
  assign pd = q.pd_sync[1];
  assign wr_done = q.wr_sync[1] & ~q.wr_prev;
  assign rd_end = ~q.rd_sync[1] & q.rd_prev;
  // data of the finished conversion carries the config it brings in
  assign conv_done = (q.st == CONV_RUN) & (q.cyc == conv_last(q.mode)) & ~pd;
  assign f_in_data = {sar_result, q.cfg_pending};
  assign f_out_ready = q.consumed;

  sample_fifo #(
    .WIDTH(`FRAME_BITS),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(conv_done),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  always_comb begin
    d = q;
    d.sample = 1'b0;
    d.cnv_sync = {q.cnv_sync[0], convert_strobe};
    d.cnv_prev = q.cnv_sync[1];
    d.pd_sync = {q.pd_sync[0], power_down_input};
    d.wr_sync = {q.wr_sync[0], rx_q.cnt[`RX_CNT_W-1]};
    d.wr_prev = q.wr_sync[1];
    d.rd_sync = {q.rd_sync[0], tx_q.cnt[`TX_CNT_W-1]};
    d.rd_prev = q.rd_sync[1];

    // the rx shift register is frozen once the word is complete
    if (wr_done) begin
      d.cfg_pending = rx_q.shift;
    end

    // a read frame is over when the link count drops back
    if (rd_end) begin
      d.consumed = 1'b1;
    end
    // the next word is loaded once the last was read out, which falls inside a frame if the fifo was empty
    if (f_out_valid & q.consumed) begin
      d.word = f_out_data;
      d.consumed = 1'b0;
    end

    unique case (q.st)
      CONV_IDLE: begin
        // busy follows the pin edge by three clocks, far inside 520 ns
        if (cnv_rise & ~pd) begin
          d.st = CONV_RUN;
          d.busy = 1'b1;
          d.sample = 1'b1;
          d.cyc = '0;
          d.mode = q.cfg_active[`CFG_MODE_BIT];
        end
      end
      CONV_RUN: begin
        if (q.cyc != conv_last(q.mode)) begin
          d.cyc = q.cyc + 1'b1;
        end else if (f_in_ready) begin
          // a full fifo holds busy high rather than drop a result
          d.st = CONV_IDLE;
          d.busy = 1'b0;
          d.cfg_active = q.cfg_pending;
        end
      end
    endcase

    // power-down aborts a running conversion
    if (pd) begin
      d.st = CONV_IDLE;
      d.busy = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // the frame's own select ends link state, so no edge is needed after it
  assign link_rst = reset | cs_n;

  always_comb begin
    rx_d = rx_q;
    // bits beyond the first sixteen are ignored within a frame
    if (!rx_q.cnt[`RX_CNT_W-1]) begin
      rx_d.shift = {rx_q.shift[`WORD_BITS-2:0], sdi};
      rx_d.cnt = rx_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  always_comb begin
    tx_d = tx_q;
    tx_d.cnt = tx_q.cnt + 1'b1;
  end

  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  // word holds until it is read out and a new result is queued; index 31 down to 0 is the inverted count
  assign sdo = q.word[~tx_q.cnt];
  assign sdo_oe = ~cs_n & ~reset & ~pd;
  assign busy = q.busy;
  assign sample_start = q.sample;
  assign conversion_mode_select = q.cfg_active[`CFG_MODE_BIT];
endmodule : sar_adc_serial_core

`default_nettype wire

// [sar_adc_serial_core_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_core_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire logic convert_strobe,
  input wire logic power_down_input,
  input wire logic busy,
  input wire logic sample_start,
  input wire logic conversion_mode_select,
  input wire logic cs_n,
  input wire logic sdo_oe
);
  logic [7:0] n_q;
  // saturates so a long fifo stall cannot wrap the count
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) n_q <= 8'h00;
    else n_q <= busy ? n_q + {7'h00, n_q != 8'hFF} : 8'h00;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence strobe_seen;
    $rose(convert_strobe) && !busy && !power_down_input;
  endsequence
  sequence busy_drop;
    $fell(busy) && !power_down_input;
  endsequence
  busy_rise_a: assert property (strobe_seen |-> ##[1:20] busy)
    else $error("busy late after strobe");
  start_pulse_a: assert property ($rose(busy) |-> sample_start)
    else $error("busy rose without start pulse");
  pulse_once_a: assert property (sample_start |=> !sample_start)
    else $error("start pulse too long");
  start_clean_a: assert property (sample_start |-> !$past(busy))
    else $error("start while busy");
  busy_len_a: assert property (busy_drop |->
    n_q >= ($past(conversion_mode_select) ? 8'h25 : 8'h21)) else $error("busy too short");
  mode_eoc_a: assert property ($changed(conversion_mode_select) |->
    $past(busy) || $past(busy, 2)) else $error("mode changed outside end of conversion");
  busy_pd_a: assert property (power_down_input [*4] |-> !busy)
    else $error("busy during power down");
  oe_cs_a: assert property (cs_n |-> !sdo_oe)
    else $error("sdo driven while deselected");
  oe_on_a: assert property ((!cs_n && !power_down_input) [*4] |-> sdo_oe)
    else $error("sdo not driven while selected");
endmodule : sar_adc_serial_core_asserts
bind sar_adc_serial_core sar_adc_serial_core_asserts u_sar_adc_serial_core_asserts (
  .mclk(mclk), .reset(reset), .convert_strobe(convert_strobe),
  .power_down_input(power_down_input), .busy(busy), .sample_start(sample_start),
  .conversion_mode_select(conversion_mode_select), .cs_n(cs_n), .sdo_oe(sdo_oe));
`default_nettype wire

// [sar_adc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_adc_host (
  input wire logic sdo,
  output logic sck,
  output logic cs_n,
  output logic sdi
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // sck stands still between frames; sdi toggles once its bits are ignored
  task automatic frame(input logic [15:0] cfg, output logic [31:0] rd);
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < 32; i++) begin
      sdi = (i < 16) ? cfg[15 - i] : ~sdi;
      #40;
      sck = 1'b1;
      rd[31 - i] = sdo;
      #80;
      sck = 1'b0;
      #40;
    end
    #80;
    cs_n = 1'b1;
    sdi = ~sdi;
  endtask : frame
endmodule : sar_adc_host
`default_nettype wire

// [tb_sar_adc_serial_core.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_serial_core;
  typedef struct packed {logic [15:0] cfg; logic [15:0] res; logic [7:0] len;} row_t;
  row_t rows [4] = '{'{16'h0002, 16'h7FFF, 8'h25}, '{16'h0000, 16'h8000, 8'h25},
    '{16'h5A5B, 16'h0001, 8'h21}, '{16'hA5A4, 16'hFFFF, 8'h25}};
  logic mclk, reset, convert_strobe, power_down_input, busy, sample_start, mode;
  logic sck, cs_n, sdi, sdo, sdo_oe;
  logic [15:0] sar_result;
  logic [31:0] rd, prev;
  int errors = 0;
  int n_checks = 0;
  int n;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  sar_adc_serial_core u_sar_adc_serial_core (.mclk(mclk), .reset(reset),
    .convert_strobe(convert_strobe), .power_down_input(power_down_input),
    .sar_result(sar_result), .busy(busy), .sample_start(sample_start),
    .conversion_mode_select(mode), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));
  sar_adc_host u_sar_adc_host (.sdo(sdo), .sck(sck), .cs_n(cs_n), .sdi(sdi));
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  // a second strobe mid-conversion must not stretch the busy count
  task automatic conv(input logic [15:0] res, output int len);
    sar_result = res;
    convert_strobe = 1'b1;
    for (len = 0; len < 20 && busy !== 1'b1; len++) tick();
    chk(sample_start, 1);
    for (len = 0; len < 60 && busy === 1'b1; len++) begin
      tick();
      convert_strobe = (len < 4 || len > 9);
    end
    convert_strobe = 1'b0;
    tick();
  endtask : conv
  initial begin
    #1500000;
    errors++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    convert_strobe = 1'b0;
    power_down_input = 1'b0;
    sar_result = 16'h0000;
    prev = 32'h00000000;
    repeat (5) @(posedge mclk);
    #2 reset = 1'b0;
    tick();
    chk(mode, 1);
    for (int k = 0; k < 4; k++) begin
      u_sar_adc_host.frame(rows[k].cfg, rd);
      chk(rd, prev);
      conv(rows[k].res, n);
      chk(n, rows[k].len);
      chk(mode, rows[k].cfg[1]);
      prev = {rows[k].res, rows[k].cfg};
      $display("row %0d done", k);
    end
    convert_strobe = 1'b1;
    repeat (8) tick();
    power_down_input = 1'b1;
    repeat (4) tick();
    chk(busy, 0);
    power_down_input = 1'b0;
    convert_strobe = 1'b0;
    tick();
    $display("power down done");
    u_sar_adc_host.frame(16'hA5A4, rd);
    chk(rd, prev);
    for (int i = 0; i < 10; i++) begin
      conv(16'h0100 + 16'(i), n);
      chk(n, i < 9 ? 33 : 60);
    end
    for (int i = 0; i < 10; i++) begin
      u_sar_adc_host.frame(16'hA5A4, rd);
      chk(rd, {16'h0100 + 16'(i), 16'hA5A4});
      repeat (8) tick();
    end
    $display("fifo done");
    convert_strobe = 1'b1;
    repeat (6) tick();
    reset = 1'b1;
    tick();
    chk(busy, 0);
    chk(mode, 1);
    chk(sdo_oe, 0);
    reset = 1'b0;
    convert_strobe = 1'b0;
    tick();
    $display("reset done");
    end_sim();
  end
endmodule : tb_sar_adc_serial_core
`default_nettype wire
